// file: spl_defs.svh
// Purpose: Constants for the sensor port line control block.
// Assumes: 125 MHz clock, 8-bit registers on a plain strobe port.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define SPL_CLK_MHZ 125
`define SPL_FAULT_MIN_US 160
`define SPL_SHUTOFF_US 240
`define SPL_RETRY_ON_US 350
`define SPL_RETRY_PERIOD_MS 26
`define SPL_FAULT_CYC (`SPL_FAULT_MIN_US * `SPL_CLK_MHZ)
`define SPL_SHUTOFF_CYC (`SPL_SHUTOFF_US * `SPL_CLK_MHZ)
`define SPL_RETRY_ON_CYC (`SPL_RETRY_ON_US * `SPL_CLK_MHZ)
`define SPL_RETRY_PERIOD_CYC (`SPL_RETRY_PERIOD_MS * 1000 * `SPL_CLK_MHZ)

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPL_ADDR_STATUS 2'h0
`define SPL_ADDR_LINECFG 2'h1
`define SPL_ADDR_AUXCFG 2'h2
`define SPL_ADDR_MODE 2'h3

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define SPL_ST_AUXLVL 5
`define SPL_ST_LINELVL 4
`define SPL_ST_FAULTIRQ 3
`define SPL_ST_REG33IRQ 2
`define SPL_ST_MAINIRQ 1
`define SPL_ST_HEATIRQ 0

// ----------------------------------------------------------------------------
// Line configuration fields
// ----------------------------------------------------------------------------
`define SPL_LC_FILTER 7
`define SPL_LC_FASTEDGE 6
`define SPL_LC_HIGHSIDE 5
`define SPL_LC_PUSHPULL 4
`define SPL_LC_DRVEN 3
`define SPL_LC_LEVEL 2
`define SPL_LC_RECEIVE_OUTPUT_DISABLE 1
`define SPL_LC_SINK 0
`define SPL_LC_RESET 8'h00

// ----------------------------------------------------------------------------
// Aux configuration and mode fields
// ----------------------------------------------------------------------------
`define SPL_AC_AUXOFF 1
`define SPL_AC_AUXSINK 0
`define SPL_AC_MASK 8'h03
`define SPL_MD_WAKE 6
`define SPL_MD_FAULT 4
`define SPL_MD_MAINLOW 3
`define SPL_MD_HEAT 2
`define SPL_MD_REG33MON 1
`define SPL_MD_REG33OFF 0
`define SPL_MD_WMASK 8'h43

`endif

// file: spl_pkg.sv
// Purpose: Types for the sensor port line control block.
// Assumes: Constants come from spl_defs.svh.
// Notes: Structs group the supply and driver signals.
package spl_pkg;

  typedef struct packed {
    logic mainLow;
    logic logic5Low;
    logic ifaceLow;
    logic reg33Low;
  } spl_supply_t;

  typedef struct packed {
    logic enable;
    logic highDrive;
    logic lowDrive;
    logic fastEdge;
  } spl_drive_t;

  typedef enum logic [3:0] {
    SPL_F_IDLE = 4'b0001,
    SPL_F_ARMED = 4'b0010,
    SPL_F_OFF = 4'b0100,
    SPL_F_RETRY = 4'b1000
  } spl_fault_t;

endpackage

// file: spl_interval.sv
// Purpose: Saturating interval timer that reports when a count elapses.
// Assumes: Synchronous active-low reset; start restarts the count.
// Notes: Used for overcurrent persistence, shutoff delay and retry timing.
`timescale 1ns/1ps
`default_nettype none
module spl_interval #(
  parameter int W = 22
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (start || !run) begin
      cnt_r <= '0;
    end else if (cnt_r != limit) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done = run && !start && (cnt_r == limit);

endmodule
`default_nettype wire

// file: spl_line_ctrl.sv
// Purpose: Control and supervision of a 24V single-wire sensor port line.
// Assumes: All inputs synchronous to clk; analog monitors arrive as levels.
// Notes: Registers sit on a strobe port; read data stand one cycle later.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spl_defs.svh"
module spl_line_ctrl #(
  parameter int FAULT_CYC = `SPL_FAULT_CYC,
  parameter int SHUTOFF_CYC = `SPL_SHUTOFF_CYC,
  parameter int RETRY_ON_CYC = `SPL_RETRY_ON_CYC,
  parameter int RETRY_PERIOD_CYC = `SPL_RETRY_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic tx_enable_pin,
  input wire logic tx_comm_input,
  input wire logic tx_level_input,
  input wire logic wakeup_enable_pin,
  input wire spl_pkg::spl_supply_t supplyLow,
  input wire logic overCurrent,
  input wire logic lineBelowLow,
  input wire logic lineAboveHigh,
  input wire logic aux_input,
  input wire logic tempWarnHigh,
  input wire logic tempWarnClear,
  input wire logic tempShutdown,
  output spl_pkg::spl_drive_t lineDrive,
  output logic rxOut,
  output logic auxOut,
  output logic filterCornerHigh,
  output logic lineSinkOn,
  output logic auxSinkOn,
  output logic reg33Off,
  output logic uvOut,
  output logic uvOe,
  output logic irqOut_n
);

  localparam int TW = 22;

  initial begin
    if (RETRY_PERIOD_CYC >= (1 << TW) || RETRY_PERIOD_CYC <= RETRY_ON_CYC ||
        SHUTOFF_CYC <= FAULT_CYC || FAULT_CYC < 1) begin
      $error("spl_line_ctrl: timing parameters out of range");
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] lineCfg_r;
  logic [7:0] auxCfg_r;
  logic sw_wakeup_enable_r;
  logic reg33_monitor_enable_r;
  logic reg33_disable_r;
  logic line_fault_flag_r;
  logic main_supply_low_flag_r;
  logic overheat_flag_r;
  logic line_fault_irq_flag_r;
  logic reg33_low_irq_flag_r;
  logic main_supply_low_irq_flag_r;
  logic overheat_irq_flag_r;
  logic [7:0] regRdata_r;
  logic powerGood_r;

  // Interface logic is down whenever the 5V or interface supply is low.
  logic logicDown;
  assign logicDown = supplyLow.logic5Low || supplyLow.ifaceLow;

  logic wrEn;
  logic rdEn;
  logic statusRead;
  assign wrEn = regWr && !logicDown;
  assign rdEn = regRd && !logicDown;
  assign statusRead = rdEn && (regAddr == `SPL_ADDR_STATUS);

  // Config contents survive other supply dips; only nrst clears them.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lineCfg_r <= `SPL_LC_RESET;
      auxCfg_r <= 8'h00;
      sw_wakeup_enable_r <= 1'b0;
      reg33_monitor_enable_r <= 1'b0;
      reg33_disable_r <= 1'b0;
    end else if (wrEn) begin
      case (regAddr)
        `SPL_ADDR_LINECFG: lineCfg_r <= regWdata;
        `SPL_ADDR_AUXCFG: auxCfg_r <= regWdata & `SPL_AC_MASK;
        `SPL_ADDR_MODE: begin
          sw_wakeup_enable_r <= regWdata[`SPL_MD_WAKE];
          reg33_monitor_enable_r <= regWdata[`SPL_MD_REG33MON];
          reg33_disable_r <= regWdata[`SPL_MD_REG33OFF];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Fault detection and autoretry
  // --------------------------------------------------------------------------
  spl_pkg::spl_fault_t fState_r;
  logic openDrain;
  logic drvReq;
  logic drvOn;
  logic voltFault;
  logic ocPersist;
  logic shutDone;
  logic retryWaitDone;
  logic retryOnDone;
  logic isShort_r;
  logic faultCond;

  assign openDrain = !lineCfg_r[`SPL_LC_PUSHPULL];
  // Voltage error: open-drain, driver off, line stuck between thresholds.
  assign voltFault = openDrain && !drvOn && !lineBelowLow && !lineAboveHigh;

  // Overcurrent must persist without break; any gap restarts the count.
  spl_interval #(.W(TW)) ocTimer (
    .clk(clk),
    .nrst(nrst),
    .start(1'b0),
    .run(overCurrent && drvOn),
    .limit(TW'(FAULT_CYC)),
    .done(ocPersist)
  );

  assign faultCond = ocPersist || voltFault;

  // Shutoff counts from the start of the condition, overcurrent or voltage.
  spl_interval #(.W(TW)) shutTimer (
    .clk(clk),
    .nrst(nrst),
    .start(1'b0),
    .run((overCurrent && drvOn) || voltFault),
    .limit(TW'(SHUTOFF_CYC)),
    .done(shutDone)
  );

  spl_interval #(.W(TW)) waitTimer (
    .clk(clk),
    .nrst(nrst),
    .start(1'b0),
    .run(fState_r == spl_pkg::SPL_F_OFF),
    .limit(TW'(RETRY_PERIOD_CYC - RETRY_ON_CYC)),
    .done(retryWaitDone)
  );

  spl_interval #(.W(TW)) onTimer (
    .clk(clk),
    .nrst(nrst),
    .start(1'b0),
    .run(fState_r == spl_pkg::SPL_F_RETRY),
    .limit(TW'(RETRY_ON_CYC)),
    .done(retryOnDone)
  );

  // Off and retry windows add to one 26ms cycle per attempt.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fState_r <= spl_pkg::SPL_F_IDLE;
      isShort_r <= 1'b0;
    end else begin
      case (fState_r)
        spl_pkg::SPL_F_IDLE: begin
          if (faultCond) begin
            fState_r <= spl_pkg::SPL_F_ARMED;
            isShort_r <= ocPersist;
          end
        end
        spl_pkg::SPL_F_ARMED: begin
          if (shutDone) begin
            fState_r <= isShort_r ? spl_pkg::SPL_F_OFF : spl_pkg::SPL_F_IDLE;
          end else if (!(overCurrent && drvOn) && !voltFault) begin
            fState_r <= spl_pkg::SPL_F_IDLE;
          end
        end
        spl_pkg::SPL_F_OFF: begin
          if (retryWaitDone) begin
            fState_r <= spl_pkg::SPL_F_RETRY;
          end
        end
        spl_pkg::SPL_F_RETRY: begin
          if (retryOnDone) begin
            fState_r <= overCurrent ? spl_pkg::SPL_F_OFF : spl_pkg::SPL_F_IDLE;
          end
        end
        default: fState_r <= spl_pkg::SPL_F_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Power-up gate and wake-up
  // --------------------------------------------------------------------------
  logic anyLow;
  assign anyLow = supplyLow.mainLow || logicDown || supplyLow.reg33Low;

  // Power good latches once every monitor is clear; indicator floats until.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      powerGood_r <= 1'b0;
    end else if (!anyLow) begin
      powerGood_r <= 1'b1;
    end
  end

  logic wakeMode;
  logic txLow;
  logic wakeDrv;
  logic prevLine_r;
  logic wakeLevel_r;
  logic txLow_r;
  assign wakeMode = wakeup_enable_pin || sw_wakeup_enable_r;
  assign txLow = !(tx_comm_input && tx_level_input);
  assign wakeDrv = wakeMode && txLow;

  // Remember the line level; on the wake-up edge drive its opposite.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prevLine_r <= 1'b0;
      wakeLevel_r <= 1'b0;
      txLow_r <= 1'b0;
    end else begin
      txLow_r <= txLow;
      if (!txLow) begin
        prevLine_r <= lineAboveHigh;
      end
      if (txLow && !txLow_r) begin
        wakeLevel_r <= !prevLine_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Driver outputs
  // --------------------------------------------------------------------------
  logic driveLevel;
  logic drvBlocked;
  logic bothRails;
  assign drvReq = tx_enable_pin || lineCfg_r[`SPL_LC_DRVEN] || wakeDrv;
  assign drvBlocked = !powerGood_r || supplyLow.mainLow || logicDown ||
                      tempShutdown ||
                      fState_r == spl_pkg::SPL_F_OFF;
  assign drvOn = drvReq && !drvBlocked;
  // The first wake-up cycle must not use a stale level, so it reads the line memory.
  assign driveLevel = wakeDrv ? (txLow_r ? wakeLevel_r : !prevLine_r) : txLow;
  // A wake-up pulse may need either rail, so it drives push-pull.
  assign bothRails = lineCfg_r[`SPL_LC_PUSHPULL] || wakeDrv;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lineDrive <= '0;
    end else begin
      lineDrive.enable <= drvOn;
      // Open-drain only drives its own rail; the other is left to the load.
      lineDrive.highDrive <= drvOn && driveLevel &&
                             (bothRails || lineCfg_r[`SPL_LC_HIGHSIDE]);
      lineDrive.lowDrive <= drvOn && !driveLevel &&
                            (bothRails || !lineCfg_r[`SPL_LC_HIGHSIDE]);
      lineDrive.fastEdge <= lineCfg_r[`SPL_LC_FASTEDGE];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxOut <= 1'b1;
      auxOut <= 1'b1;
      filterCornerHigh <= 1'b0;
      lineSinkOn <= 1'b0;
      auxSinkOn <= 1'b0;
      reg33Off <= 1'b0;
    end else begin
      rxOut <= lineCfg_r[`SPL_LC_RECEIVE_OUTPUT_DISABLE] ? 1'b1 : lineBelowLow;
      auxOut <= auxCfg_r[`SPL_AC_AUXOFF] ? 1'b0 : !aux_input;
      filterCornerHigh <= lineCfg_r[`SPL_LC_FILTER];
      lineSinkOn <= lineCfg_r[`SPL_LC_SINK] && !drvOn && !tempShutdown;
      auxSinkOn <= auxCfg_r[`SPL_AC_AUXSINK] && !tempShutdown;
      reg33Off <= reg33_disable_r;
    end
  end

  // --------------------------------------------------------------------------
  // Flags and interrupt
  // --------------------------------------------------------------------------
  // A set in the same cycle as the status read wins, so no event is lost.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_fault_flag_r <= 1'b0;
      main_supply_low_flag_r <= 1'b0;
      overheat_flag_r <= 1'b0;
    end else begin
      line_fault_flag_r <= faultCond || fState_r != spl_pkg::SPL_F_IDLE;
      main_supply_low_flag_r <= supplyLow.mainLow;
      if (tempWarnHigh) begin
        overheat_flag_r <= 1'b1;
      end else if (tempWarnClear) begin
        overheat_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_fault_irq_flag_r <= 1'b0;
      reg33_low_irq_flag_r <= 1'b0;
      main_supply_low_irq_flag_r <= 1'b0;
      overheat_irq_flag_r <= 1'b0;
    end else begin
      line_fault_irq_flag_r <= faultCond || (line_fault_irq_flag_r && !statusRead) ||
                               (statusRead && fState_r != spl_pkg::SPL_F_IDLE);
      reg33_low_irq_flag_r <= supplyLow.reg33Low || (reg33_low_irq_flag_r && !statusRead);
      main_supply_low_irq_flag_r <= supplyLow.mainLow ||
                                    (main_supply_low_irq_flag_r && !statusRead);
      overheat_irq_flag_r <= (tempWarnHigh && !overheat_flag_r) ||
                             (overheat_irq_flag_r && !statusRead);
    end
  end

  logic anyIrq;
  assign anyIrq = line_fault_irq_flag_r || reg33_low_irq_flag_r ||
                  main_supply_low_irq_flag_r || overheat_irq_flag_r;
  // Interrupt pin is not available while the logic supply is down.
  assign irqOut_n = logicDown ? 1'b1 : !anyIrq;

  // Indicator is open drain: oe high pulls it, low lets it float high.
  assign uvOut = 1'b0;
  assign uvOe = powerGood_r && !supplyLow.mainLow && !logicDown &&
                !(supplyLow.reg33Low && reg33_monitor_enable_r);

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      regRdata_r <= 8'h00;
    end else if (rdEn) begin
      case (regAddr)
        `SPL_ADDR_STATUS: regRdata_r <= {2'b00, !aux_input, lineBelowLow,
                                         line_fault_irq_flag_r, reg33_low_irq_flag_r,
                                         main_supply_low_irq_flag_r, overheat_irq_flag_r};
        `SPL_ADDR_LINECFG: regRdata_r <= lineCfg_r;
        `SPL_ADDR_AUXCFG: regRdata_r <= auxCfg_r;
        `SPL_ADDR_MODE: regRdata_r <= {1'b0, sw_wakeup_enable_r, 1'b0, line_fault_flag_r,
                                       main_supply_low_flag_r, overheat_flag_r,
                                       reg33_monitor_enable_r, reg33_disable_r};
        default: regRdata_r <= 8'h00;
      endcase
    end else begin
      regRdata_r <= 8'h00;
    end
  end
  assign regRdata = regRdata_r;

endmodule
`default_nettype wire

// file: spl_line_ctrl_props.sv
// Purpose: Concurrent checks on the ports of the line control block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Fault timing is judged with a persistence counter, not long repeats.
`timescale 1ns/1ps
`default_nettype none
module spl_line_ctrl_props #(
  parameter int FAULT_CYC = 8,
  parameter int SHUTOFF_CYC = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire spl_pkg::spl_supply_t supplyLow,
  input wire logic overCurrent,
  input wire logic lineBelowLow,
  input wire logic aux_input,
  input wire logic tempWarnHigh,
  input wire logic tempShutdown,
  input wire spl_pkg::spl_drive_t lineDrive,
  input wire logic rxOut,
  input wire logic auxOut,
  input wire logic lineSinkOn,
  input wire logic auxSinkOn,
  input wire logic uvOe,
  input wire logic irqOut_n
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic logicOk;
  logic [15:0] ocCnt;
  assign logicOk = !supplyLow.logic5Low && !supplyLow.ifaceLow;
  // Counts only while the driver is really on, so retries restart the count.
  always_ff @(posedge clk) begin
    if (!nrst || !(overCurrent && lineDrive.enable)) begin
      ocCnt <= 16'h0000;
    end else if (ocCnt != 16'hffff) begin
      ocCnt <= ocCnt + 16'h0001;
    end
  end
  sequence s_main_low;
    supplyLow.mainLow && logicOk ##1 supplyLow.mainLow && logicOk ##1 logicOk;
  endsequence
  sequence s_heat_rise;
    $rose(tempWarnHigh) && logicOk ##1 logicOk ##1 logicOk;
  endsequence
  a_rx_follow_line: assert property (!rxOut |-> !$past(lineBelowLow))
    else $error("receive output low while line was low");
  a_aux_inverted: assert property ($past(nrst) && auxOut |-> !$past(aux_input))
    else $error("aux output high while aux input was high");
  a_supply_drv_off: assert property (!logicOk || supplyLow.mainLow |=> !lineDrive.enable)
    else $error("driver on during supply undervoltage");
  a_hot_shutoff: assert property (tempShutdown |=> !(lineDrive.enable || lineSinkOn || auxSinkOn))
    else $error("driver or sink on in thermal shutdown");
  a_sink_drv_excl: assert property (!(lineDrive.enable && lineSinkOn))
    else $error("line sink on while driver enabled");
  a_main_low_irq: assert property (s_main_low |-> !irqOut_n)
    else $error("main undervoltage without interrupt");
  a_heat_irq_set: assert property (s_heat_rise |-> !irqOut_n)
    else $error("overtemperature without interrupt");
  a_irq_gated_off: assert property (!logicOk |-> irqOut_n)
    else $error("interrupt driven during logic undervoltage");
  a_main_uv_ind: assert property (supplyLow.mainLow |-> !uvOe)
    else $error("indicator not asserted on main undervoltage");
  a_fault_irq_time: assert property (ocCnt == 16'(FAULT_CYC + 2) && logicOk |-> !irqOut_n)
    else $error("persistent overcurrent without fault interrupt");
  a_shutoff_bound: assert property (ocCnt <= 16'(SHUTOFF_CYC + 3))
    else $error("driver still on after shutoff delay");
endmodule
bind spl_line_ctrl spl_line_ctrl_props #(.FAULT_CYC(FAULT_CYC), .SHUTOFF_CYC(SHUTOFF_CYC))
  spl_line_ctrl_props_i (.clk, .nrst, .supplyLow, .overCurrent, .lineBelowLow, .aux_input,
  .tempWarnHigh, .tempShutdown, .lineDrive, .rxOut, .auxOut, .lineSinkOn, .auxSinkOn, .uvOe,
  .irqOut_n);
`default_nettype wire

// file: spl_remote_dev.sv
// Purpose: Behavioural field device at the far end of the line.
// Assumes: Driver controls are registered, so a combinational answer is safe.
// Notes: A short pulls the line to ground while the driver sources high.
`timescale 1ns/1ps
`default_nettype none
module spl_remote_dev (
  input wire spl_pkg::spl_drive_t lineDrive,
  input wire logic shortOn,
  input wire logic floatOn,
  input wire logic remLvl,
  output logic overCurrent,
  output logic lineBelowLow,
  output logic lineAboveHigh
);
  // ---------------------------------------------------------------------------
  // Model
  // ---------------------------------------------------------------------------
  logic lvl;
  logic driven;
  always_comb begin
    driven = lineDrive.enable && (lineDrive.highDrive || lineDrive.lowDrive);
    lvl = driven ? lineDrive.highDrive : remLvl;
    overCurrent = shortOn && lineDrive.enable && lineDrive.highDrive;
    if (shortOn) begin
      lvl = 1'b0;
    end
    // An undriven floating line sits between both thresholds.
    lineAboveHigh = lvl && !(floatOn && !driven);
    lineBelowLow = !lvl && !(floatOn && !driven);
  end
endmodule
`default_nettype wire

// file: spl_line_ctrl_tb_top.sv
// Purpose: Self-checking bench for the line control block.
// Assumes: Short timing parameters; checks sample just before a rising edge.
// Notes: Each scenario leaves inputs idle for the next one.
`timescale 1ns/1ps
`default_nettype none
module spl_line_ctrl_tb_top;
  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  localparam int FC = 8;
  localparam int SC = 12;
  localparam logic [7:0] CF [7] = '{8'h18, 8'h18, 8'h08, 8'h08, 8'h28, 8'h28, 8'h58};
  localparam logic [6:0] TC = 7'h26;
  localparam logic [3:0] DX [7] = '{4'hc, 4'ha, 4'ha, 4'h8, 4'hc, 4'h8, 4'hd};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic tx_enable_pin = 1'b0;
  logic tx_comm_input = 1'b1;
  logic tx_level_input = 1'b1;
  logic wakeup_enable_pin = 1'b0;
  logic aux_input = 1'b1;
  logic tempWarnHigh = 1'b0;
  logic tempWarnClear = 1'b0;
  logic tempShutdown = 1'b0;
  logic shortOn = 1'b0;
  logic floatOn = 1'b0;
  logic remLvl = 1'b1;
  spl_pkg::spl_supply_t supplyLow = 4'hf;
  spl_pkg::spl_drive_t lineDrive;
  logic [7:0] regRdata;
  logic overCurrent, lineBelowLow, lineAboveHigh, rxOut, auxOut, filterCornerHigh;
  logic lineSinkOn, auxSinkOn, reg33Off, uvOut, uvOe, irqOut_n;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  spl_line_ctrl #(.FAULT_CYC(FC), .SHUTOFF_CYC(SC), .RETRY_ON_CYC(10), .RETRY_PERIOD_CYC(40))
    spl_line_ctrl_i (.clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .tx_enable_pin, .tx_comm_input, .tx_level_input, .wakeup_enable_pin, .supplyLow,
    .overCurrent, .lineBelowLow, .lineAboveHigh, .aux_input, .tempWarnHigh, .tempWarnClear,
    .tempShutdown, .lineDrive, .rxOut, .auxOut, .filterCornerHigh, .lineSinkOn, .auxSinkOn,
    .reg33Off, .uvOut, .uvOe, .irqOut_n);
  spl_remote_dev spl_remote_dev_i (.lineDrive, .shortOn, .floatOn, .remLvl, .overCurrent,
    .lineBelowLow, .lineAboveHigh);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // Read data are taken in the single cycle after the strobe.
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    chk(regRdata & m, e);
  endtask
  task automatic t_power();
    tx_enable_pin <= 1'b1;
    cyc(3);
    chk({uvOe, lineDrive.enable, irqOut_n}, 3'b001);
    supplyLow <= 4'h0;
    cyc(3);
    chk({uvOe, lineDrive.enable}, 2'b11);
    rd(2'h0, 8'h00, 8'h00);
    chk(irqOut_n, 1'b1);
    tx_enable_pin <= 1'b0;
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 7; i++) begin
      wr(2'h1, CF[i]);
      tx_comm_input <= TC[i];
      cyc(3);
      chk(lineDrive, DX[i]);
    end
    wr(2'h1, 8'h10);
    cyc(3);
    chk(lineDrive.enable, 1'b0);
    tx_enable_pin <= 1'b1;
    cyc(3);
    chk(lineDrive.enable, 1'b1);
    tx_enable_pin <= 1'b0;
    tx_comm_input <= 1'b1;
  endtask
  task automatic t_rx();
    wr(2'h1, 8'h82);
    aux_input <= 1'b0;
    cyc(3);
    chk({filterCornerHigh, rxOut, auxOut}, 3'b111);
    wr(2'h1, 8'h01);
    wr(2'h2, 8'h02);
    cyc(3);
    chk({filterCornerHigh, rxOut, auxOut, lineSinkOn}, 4'h1);
    tx_enable_pin <= 1'b1;
    cyc(3);
    chk(lineSinkOn, 1'b0);
    tx_enable_pin <= 1'b0;
    aux_input <= 1'b1;
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h00);
  endtask
  task automatic t_short();
    wr(2'h1, 8'h18);
    tx_comm_input <= 1'b0;
    cyc(3);
    shortOn <= 1'b1;
    cyc(4);
    shortOn <= 1'b0;
    cyc(FC + 6);
    chk(irqOut_n, 1'b1);
    shortOn <= 1'b1;
    cyc(FC - 2);
    chk(irqOut_n, 1'b1);
    cyc(5);
    chk({irqOut_n, lineDrive.enable}, 2'b01);
    cyc(SC - FC);
    chk(lineDrive.enable, 1'b0);
    cyc(20);
    chk(lineDrive.enable, 1'b0);
    for (int i = 0; i < 20 && lineDrive.enable !== 1'b1; i++) @(posedge clk);
    cyc(5);
    chk(lineDrive.enable, 1'b1);
    cyc(8);
    chk(lineDrive.enable, 1'b0);
    rd(2'h0, 8'h08, 8'h08);
    rd(2'h0, 8'h08, 8'h08);
    shortOn <= 1'b0;
    tx_comm_input <= 1'b1;
    cyc(60);
    rd(2'h0, 8'h0f, 8'h08);
    rd(2'h0, 8'h0f, 8'h00);
    chk(irqOut_n, 1'b1);
    wr(2'h1, 8'h00);
  endtask
  task automatic t_volt();
    floatOn <= 1'b1;
    for (int i = 0; i < SC + 10 && irqOut_n !== 1'b0; i++) @(posedge clk);
    chk(irqOut_n, 1'b0);
    floatOn <= 1'b0;
    cyc(3);
    rd(2'h0, 8'h0f, 8'h08);
    rd(2'h0, 8'h0f, 8'h00);
  endtask
  task automatic t_supply();
    tx_enable_pin <= 1'b1;
    supplyLow <= 4'h8;
    cyc(3);
    chk({irqOut_n, uvOe, lineDrive.enable}, 3'b000);
    supplyLow <= 4'h0;
    cyc(3);
    chk({irqOut_n, uvOe, lineDrive.enable}, 3'b011);
    rd(2'h0, 8'h0f, 8'h02);
    chk(irqOut_n, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(2'h1, 8'h40);
      supplyLow <= (i == 0) ? 4'h4 : 4'h2;
      cyc(3);
      chk({irqOut_n, lineDrive.enable}, 2'b10);
      rd(2'h1, 8'hff, 8'h00);
      wr(2'h1, 8'h00);
      supplyLow <= 4'h0;
      cyc(3);
      chk(lineDrive.enable, 1'b1);
      rd(2'h1, 8'hff, 8'h40);
    end
    wr(2'h1, 8'h00);
    tx_enable_pin <= 1'b0;
  endtask
  task automatic t_reg33();
    supplyLow <= 4'h1;
    cyc(3);
    chk({irqOut_n, uvOe}, 2'b01);
    supplyLow <= 4'h0;
    rd(2'h0, 8'h0f, 8'h04);
    wr(2'h3, 8'h03);
    supplyLow <= 4'h1;
    cyc(3);
    chk({uvOe, uvOut, reg33Off}, 3'b001);
    supplyLow <= 4'h0;
    cyc(3);
    chk({irqOut_n, uvOe}, 2'b01);
    rd(2'h0, 8'h0f, 8'h04);
    wr(2'h3, 8'h00);
  endtask
  task automatic t_heat();
    tempWarnHigh <= 1'b1;
    cyc(4);
    chk(irqOut_n, 1'b0);
    tempWarnHigh <= 1'b0;
    rd(2'h0, 8'h0f, 8'h01);
    chk(irqOut_n, 1'b1);
    rd(2'h3, 8'h04, 8'h04);
    tempWarnClear <= 1'b1;
    cyc(3);
    rd(2'h3, 8'h04, 8'h00);
    tempWarnClear <= 1'b0;
  endtask
  task automatic t_hot();
    tx_enable_pin <= 1'b1;
    wr(2'h2, 8'h01);
    cyc(3);
    chk({lineDrive.enable, auxSinkOn}, 2'b11);
    tempShutdown <= 1'b1;
    cyc(3);
    chk({lineDrive.enable, auxSinkOn}, 2'b00);
    rd(2'h2, 8'h03, 8'h01);
    tempShutdown <= 1'b0;
    cyc(3);
    chk({lineDrive.enable, auxSinkOn}, 2'b11);
    tx_enable_pin <= 1'b0;
    wr(2'h2, 8'h00);
  endtask
  task automatic t_wake();
    for (int i = 0; i < 2; i++) begin
      remLvl <= (i == 0);
      cyc(3);
      if (i == 0) begin
        wakeup_enable_pin <= 1'b1;
      end else begin
        wr(2'h3, 8'h40);
      end
      cyc(2);
      if (i == 0) begin
        tx_comm_input <= 1'b0;
      end else begin
        tx_level_input <= 1'b0;
      end
      cyc(3);
      chk(lineDrive[3:1], (i == 0) ? 3'b101 : 3'b110);
      cyc(9997);
      tx_comm_input <= 1'b1;
      tx_level_input <= 1'b1;
      cyc(3);
      chk(lineDrive.enable, 1'b0);
      wakeup_enable_pin <= 1'b0;
      wr(2'h3, 8'h00);
    end
    remLvl <= 1'b1;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_power();
    t_cfg();
    t_rx();
    t_short();
    t_volt();
    t_supply();
    t_reg33();
    t_heat();
    t_hot();
    t_wake();
    tally_and_finish();
  end
endmodule
`default_nettype wire
